/* File: sim/sacp_host_model.sv */
// Purpose: Host side of the result lines.
// Assumes: Lines have no pull; released lines show a moving pattern.
// Notes: Takes the first driven word after busy_n rises.
`include "sacp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sacp_host_model (
    input  wire logic                   mclk,
    input  wire logic                   busy_n,
    input  wire logic [`SACP_RES_W-1:0] data_out,
    input  wire logic [`SACP_RES_W-1:0] data_oe,
    output var  logic [`SACP_RES_W-1:0] bus,
    output var  logic [`SACP_RES_W-1:0] captured
);
    logic                   busy_q;
    logic                   pend_q;
    logic [`SACP_RES_W-1:0] last_q;
    always_comb begin
        for (int i = 0; i < `SACP_RES_W; i++) begin
            bus[i] = data_oe[i] ? data_out[i] : ~last_q[i];
        end
    end
    // capture once drivers follow the busy rise
    always_ff @(posedge mclk) begin
        last_q <= bus;
        busy_q <= busy_n;
        if (busy_n && !busy_q) begin
            pend_q <= 1'b1;
        end else if (pend_q && &data_oe) begin
            captured <= bus;
            pend_q   <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: sim/test_sacp_port.sv */
// Purpose: Self-checking bench for the conversion control port.
// Assumes: Short conversion count; host model reads the lines.
// Notes: Pins settle six edges before outputs are judged.
`include "sacp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module test_sacp_port;
    import sacp_pkg::*;
    localparam logic [`SACP_CNT_W-1:0] CONV = 10'h014;
    logic        mclk = 1'b0, reset_n = 1'b0, chip_sel_n = 1'b1;
    logic        read_conv = 1'b1, high_byte_select = 1'b0;
    logic [11:0] sample_value = 12'h000, data_out, data_oe, bus, captured;
    logic        busy_n, conv_done;
    int          miscompares = 0, total_checks = 0, low_run = 0, low_len = 0;
    int          done_cnt = 0;
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        if (conv_done === 1'b1) begin
            done_cnt <= done_cnt + 1;
        end
        if (busy_n === 1'b0) begin
            low_run <= low_run + 1;
        end else if (low_run != 0) begin
            low_len <= low_run;
            low_run <= 0;
        end
    end
    sacp_port #(.CONV_CYCLES(CONV)) i_sacp_port (.mclk(mclk),
        .reset_n(reset_n), .chip_sel_n(chip_sel_n), .read_conv(read_conv),
        .high_byte_select(high_byte_select), .sample_value(sample_value),
        .busy_n(busy_n), .conv_done(conv_done), .data_out(data_out),
        .data_oe(data_oe));
    sacp_host_model i_sacp_host_model (.mclk(mclk), .busy_n(busy_n),
        .data_out(data_out), .data_oe(data_oe), .bus(bus),
        .captured(captured));
    task automatic check(input string what, input logic [11:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic pins(input logic cs, rc, hb, input logic [11:0] v);
        @(posedge mclk);
        chip_sel_n <= cs;
        read_conv <= rc;
        high_byte_select <= hb;
        sample_value <= v;
        repeat (6) @(posedge mclk);
        #1;
    endtask
    task automatic wait_idle;
        int k;
        for (k = 0; k < 60 && busy_n !== 1'b1; k++) @(posedge mclk);
        if (k == 60) begin
            miscompares++;
            summarize();
        end
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic convert(input logic [11:0] v);
        int n0;
        n0 = done_cnt;
        pins(1'b0, 1'b1, 1'b0, v);
        pins(1'b0, 1'b0, 1'b0, v);
        // R/C back high while busy: lines must stay floated
        pins(1'b0, 1'b1, 1'b0, v);
        check("oe busy", data_oe, 12'h000);
        // Second fall while converting must not restart
        pins(1'b0, 1'b0, 1'b0, v);
        wait_idle();
        check("busy len", 12'(low_len), 12'(CONV));
        check("oe rc low", data_oe, 12'h000);
        pins(1'b0, 1'b1, 1'b0, v);
        check("done", 12'(done_cnt - n0), 12'h001);
        check("captured", captured, v);
        check("oe read", data_oe, 12'hFFF);
        check("word", bus, v);
        pins(1'b0, 1'b1, 1'b1, v);
        check("hbyte", bus, {v[11:8], 4'h0, v[11:8]});
        pins(1'b1, 1'b1, 1'b1, v);
        check("oe cs", data_oe, 12'h000);
    endtask
    task automatic pulse(input logic [11:0] v);
        int n0;
        n0 = done_cnt;
        pins(1'b0, 1'b1, 1'b0, v);
        // Short low pulse: r/c is high again before busy rises
        pins(1'b0, 1'b0, 1'b0, v);
        pins(1'b0, 1'b1, 1'b0, v);
        wait_idle();
        check("pulse done", 12'(done_cnt - n0), 12'h001);
        check("pulse captured", captured, v);
        check("pulse busy len", 12'(low_len), 12'(CONV));
    endtask
    task automatic refuse;
        int n0;
        n0 = done_cnt;
        pins(1'b1, 1'b0, 1'b0, 12'h555);
        check("cs start", {11'h0, busy_n}, 12'h001);
        pins(1'b1, 1'b1, 1'b0, 12'h555);
        pins(1'b0, 1'b1, 1'b1, 12'h555);
        pins(1'b0, 1'b0, 1'b1, 12'h555);
        check("hb start", {11'h0, busy_n}, 12'h001);
        check("oe hb rc", data_oe, 12'h000);
        check("no done", 12'(done_cnt - n0), 12'h000);
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        convert(12'hA5C);
        pulse(12'h0C3);
        convert(12'h3F0);
        refuse();
        summarize();
    end
endmodule
`default_nettype wire

/* File: src/sacp_defines.svh */
// Purpose: Constants for the converter control and parallel output port.
// Assumes: 200 MHz mclk; conversion timing modelled by a cycle count.
// Notes: Constants only; the package holds the types.
// Notes on behaviour
// - Upper four output lines always carry result bits eleven to eight.
// - Middle four lines carry bits seven to four, low in high-byte mode.
// - Lowest four lines carry bits three to zero, or eleven to eight.
// - With high-byte select low, all twelve bits form one parallel word.
// - High-byte select must be low to start; device refuses otherwise.
// - Convert on read/convert falling edge with select low, byte low, idle.
// - Chip select high floats every data output line.
// - Chip select low is needed both to convert and to read data.
// - Busy output is low throughout a conversion, high once done.
// - Result is valid by the rising edge of busy.
// - During conversion outputs float and read/convert pulses are ignored.
// - Drivers enabled only with select low, read/convert high, busy high.
`ifndef SACP_DEFINES_SVH
`define SACP_DEFINES_SVH
`define SACP_RES_W        12
`define SACP_CONV_TIME_NS 2700
`define SACP_CLK_PERIOD_NS 5
`define SACP_CONV_CYCLES `SACP_CNT_W'(`SACP_CONV_TIME_NS / `SACP_CLK_PERIOD_NS)
`define SACP_CNT_W        10
`define SACP_RESULT_RST   12'h000
`define SACP_NIBBLE_ZERO  4'h0
`define SACP_CNT_ONE      10'h001
`define SACP_CNT_ZERO     10'h000
`define SACP_SYNC_RST     3'h7
`define SACP_ALL_ON       12'hFFF
`define SACP_TOP_HI       11
`define SACP_TOP_LO       8
`define SACP_MID_HI       7
`define SACP_MID_LO       4
`define SACP_LOW_HI       3
`define SACP_LOW_LO       0
`endif

/* File: src/sacp_pkg.sv */
// Purpose: Types for the converter control and parallel output port.
// Assumes: Used together with sacp_defines.svh.
// Notes: One-bit state encoding fixed by the enum, idle zero, converting one.
package sacp_pkg;
    typedef enum logic [0:0] {SACP_IDLE, SACP_CONV} sacp_state_type;
endpackage

/* File: src/sacp_port.sv */
// Purpose: Start conversions, show busy and drive the 12-bit result port.
// Assumes: Control pins are asynchronous; sample value arrives on mclk.
// Notes: Outputs lag pins by two sync stages plus one register stage.
`include "sacp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sacp_port
    import sacp_pkg::*;
#(
    parameter logic [`SACP_CNT_W-1:0] CONV_CYCLES = `SACP_CONV_CYCLES
) (
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    input  wire logic                   chip_sel_n,
    input  wire logic                   read_conv,
    input  wire logic                   high_byte_select,
    input  wire logic [`SACP_RES_W-1:0] sample_value,
    output var  logic                   busy_n,
    output var  logic                   conv_done,
    output var  logic [`SACP_RES_W-1:0] data_out,
    output var  logic [`SACP_RES_W-1:0] data_oe
);
    logic [2:0]             meta_q;
    logic [2:0]             sync_q;
    logic                   rc_prev_q;
    sacp_state_type         state_q;
    logic [`SACP_CNT_W-1:0] cnt_q;
    logic [`SACP_CNT_W-1:0] low_cnt_q;
    logic [`SACP_RES_W-1:0] result_q;
    logic                   cs_n_s;
    logic                   rc_s;
    logic                   hbe_s;
    logic                   start;
    logic                   drive;

    // Two-stage synchronisers for cs, r/c, hbe
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= `SACP_SYNC_RST;
            sync_q <= `SACP_SYNC_RST;
        end else begin
            meta_q <= {chip_sel_n, read_conv, high_byte_select};
            sync_q <= meta_q;
        end
    end
    assign cs_n_s = sync_q[2];
    assign rc_s   = sync_q[1];
    assign hbe_s  = sync_q[0];

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rc_prev_q <= 1'b1;
        end else begin
            rc_prev_q <= rc_s;
        end
    end

    // start qualification
    // Idle state stands in for busy high; edges while converting are lost.
    assign start = rc_prev_q && !rc_s && !cs_n_s && !hbe_s
                   && (state_q == SACP_IDLE);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= SACP_IDLE;
            cnt_q   <= `SACP_CNT_ZERO;
        end else begin
            unique case (state_q)
                SACP_IDLE: begin
                    if (start) begin
                        state_q <= SACP_CONV;
                        cnt_q   <= CONV_CYCLES;
                    end
                end
                SACP_CONV: begin
                    if (cnt_q <= `SACP_CNT_ONE) begin
                        state_q <= SACP_IDLE;
                        cnt_q   <= `SACP_CNT_ZERO;
                    end else begin
                        cnt_q <= cnt_q - `SACP_CNT_ONE;
                    end
                end
            endcase
        end
    end

    // latch result in the final conversion cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            result_q  <= `SACP_RESULT_RST;
            conv_done <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            if (state_q == SACP_CONV && cnt_q <= `SACP_CNT_ONE) begin
                result_q  <= sample_value;
                conv_done <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            busy_n <= 1'b1;
        end else begin
            busy_n <= !(start || (state_q == SACP_CONV
                                  && cnt_q > `SACP_CNT_ONE));
        end
    end

    assign drive = !cs_n_s && rc_s && busy_n && (state_q == SACP_IDLE)
                   && !start;

    // byte steering onto the data lines
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            data_out <= `SACP_RESULT_RST;
            data_oe  <= `SACP_RESULT_RST;
        end else begin
            data_oe <= {`SACP_RES_W{drive}};
            if (hbe_s) begin
                data_out <= {result_q[`SACP_TOP_HI:`SACP_TOP_LO],
                             `SACP_NIBBLE_ZERO,
                             result_q[`SACP_TOP_HI:`SACP_TOP_LO]};
            end else begin
                data_out <= result_q;
            end
        end
    end

    // busy length counted for the checks below
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            low_cnt_q <= `SACP_CNT_ZERO;
        end else if (!busy_n) begin
            low_cnt_q <= low_cnt_q + `SACP_CNT_ONE;
        end else begin
            low_cnt_q <= `SACP_CNT_ZERO;
        end
    end

    // Registered outputs trail their sources by one edge, hence $past
    upper_nibble_a : assert property (
        @(posedge mclk) disable iff (!reset_n)
        data_out[`SACP_TOP_HI:`SACP_TOP_LO]
            == $past(result_q[`SACP_TOP_HI:`SACP_TOP_LO]))
        else $error("upper lines not result top nibble");
    middle_low_a : assert property (
        @(posedge mclk) disable iff (!reset_n)
        $past(hbe_s) |-> data_out[`SACP_MID_HI:`SACP_MID_LO]
            == `SACP_NIBBLE_ZERO)
        else $error("middle lines not low in byte mode");
    low_nibble_a : assert property (
        @(posedge mclk) disable iff (!reset_n)
        data_out[`SACP_LOW_HI:`SACP_LOW_LO]
            == ($past(hbe_s) ? $past(result_q[`SACP_TOP_HI:`SACP_TOP_LO])
                             : $past(result_q[`SACP_LOW_HI:`SACP_LOW_LO])))
        else $error("low lines wrong");
    full_word_a : assert property (
        @(posedge mclk) disable iff (!reset_n)
        !$past(hbe_s) |-> data_out == $past(result_q))
        else $error("word mode data wrong");

    // Byte mode must keep the sequencer idle whatever r/c does
    no_start_hbe_a : assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == SACP_IDLE && hbe_s |=> state_q == SACP_IDLE && busy_n)
        else $error("start with high byte select");
    start_cond_a : assert property (
        @(posedge mclk) disable iff (!reset_n)
        (rc_prev_q && !rc_s && !cs_n_s && !hbe_s && state_q == SACP_IDLE)
        |=> state_q == SACP_CONV && !busy_n)
        else $error("qualified edge did not start");
    cs_float_a : assert property (
        @(posedge mclk) disable iff (!reset_n)
        $past(cs_n_s) |-> data_oe == `SACP_RESULT_RST)
        else $error("driven while deselected");
    cs_no_conv_a : assert property (
        @(posedge mclk) disable iff (!reset_n)
        cs_n_s |=> !$rose(state_q == SACP_CONV))
        else $error("converted while deselected");
    busy_len_a : assert property (
        @(posedge mclk) disable iff (!reset_n)
        $fell(busy_n) |-> !busy_n [*2])
        else $error("busy pulse too short");
    busy_count_a : assert property (
        @(posedge mclk) disable iff (!reset_n)
        $rose(busy_n) |-> low_cnt_q == CONV_CYCLES)
        else $error("busy low for wrong cycle count");

    // Result and busy move on the same edge
    data_valid_a : assert property (
        @(posedge mclk) disable iff (!reset_n)
        $rose(busy_n) |-> conv_done)
        else $error("busy rose before result latched");
    result_latch_a : assert property (
        @(posedge mclk) disable iff (!reset_n)
        conv_done |-> result_q == $past(sample_value))
        else $error("latched result differs from sample");
    conv_float_a : assert property (
        @(posedge mclk) disable iff (!reset_n)
        !busy_n |=> data_oe == `SACP_RESULT_RST)
        else $error("driven during conversion");
    reload_block_a : assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == SACP_CONV
        |=> state_q == SACP_IDLE || cnt_q < $past(cnt_q))
        else $error("conversion counter reloaded");
    oe_cond_a : assert property (
        @(posedge mclk) disable iff (!reset_n)
        data_oe != `SACP_RESULT_RST |-> $past(!cs_n_s && rc_s))
        else $error("drivers on without select and read");
    oe_on_a : assert property (
        @(posedge mclk) disable iff (!reset_n)
        $past(!cs_n_s && rc_s && busy_n) |-> data_oe == `SACP_ALL_ON)
        else $error("drivers off while selected and idle");
    oe_equal_a : assert property (
        @(posedge mclk) disable iff (!reset_n)
        data_oe == {`SACP_RES_W{data_oe[0]}})
        else $error("line enables disagree");
    restart_a : assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == SACP_CONV && cnt_q > `SACP_CNT_ONE
        |=> state_q == SACP_CONV)
        else $error("conversion cut short");

    conv_cov_c  : cover property (@(posedge mclk) disable iff (!reset_n)
        $rose(busy_n));
    word_cov_c  : cover property (@(posedge mclk) disable iff (!reset_n)
        data_oe != `SACP_RESULT_RST && !hbe_s);
    byte_cov_c  : cover property (@(posedge mclk) disable iff (!reset_n)
        data_oe != `SACP_RESULT_RST && hbe_s);
    block_cov_c : cover property (@(posedge mclk) disable iff (!reset_n)
        rc_prev_q && !rc_s && !cs_n_s && hbe_s);
    restart_cov_c : cover property (@(posedge mclk) disable iff (!reset_n)
        rc_prev_q && !rc_s && state_q == SACP_CONV);
endmodule
`default_nettype wire
